// ===== logic/qld_pkg.sv
// Shared constants and types for the quad low-side driver serial control block.
// Assumes a 20 MHz system clock; all timing counts derive from CLK_NS.
package qld_pkg;
    // Frame layout
    localparam int CHANNELS = 4;
    localparam int FRAME_BITS = 8;
    localparam logic [3:0] FRAME_CNT = 4'h8;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam int CMD_LSB = 0;
    // System clock period
    localparam int CLK_NS = 50;
    // Overcurrent sense time, nominal figure, rounded up to whole cycles
    localparam int OC_SENSE_NS = 62500;
    localparam int OC_SENSE_CYC = (OC_SENSE_NS + CLK_NS - 1) / CLK_NS;
    // Overcurrent shutdown interval, nominal figure
    localparam int OC_SHUT_NS = 3940000;
    localparam int OC_SHUT_CYC = OC_SHUT_NS / CLK_NS;
    // Open-load sense time, least figure, rounded up
    localparam int OL_SENSE_NS = 12500;
    localparam int OL_SENSE_CYC = (OL_SENSE_NS + CLK_NS - 1) / CLK_NS;
    // Least gap the host leaves between frames
    localparam int HOST_GAP_NS = 1000;
    // Counter widths
    localparam int TMR_W = 17;
    localparam int OL_W = 8;
    // Synchroniser: {supply, open load[3:0], overcurrent[3:0], parallel[3:0], chip select}
    localparam int PIN_W = 14;
    localparam logic [13:0] PIN_RST = 14'h0001;
    localparam int PIN_CS = 0;
    localparam int PIN_PAR = 1;
    localparam int PIN_OC = 5;
    localparam int PIN_OL = 9;
    localparam int PIN_SUP = 13;
    // Reset values
    localparam logic [3:0] CMD_RST = 4'h0;
    localparam logic [2:0] TX_SEL_FIRST = 3'h6;
    typedef enum logic {OC_RUN, OC_SHUT} oc_state_t;
endpackage

// ===== logic/quad_lowside_driver_serial_control.sv
// Serial control and fault logic for a four-channel low-side switch.
// Assumes analog sensors deliver overcurrent, open-load and supply-fault levels
// as pins, and a host drives the serial link in clock-idle-low mode.
`timescale 1ns/1ps
module quad_lowside_driver_serial_control #(
    parameter int SHUT_CYCLES = qld_pkg::OC_SHUT_CYC
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic SCLK_I,
    input wire logic CHIP_SELECT_N_I,
    input wire logic SERIAL_IN_I,
    input wire logic PARALLEL_IN_0_I,
    input wire logic PARALLEL_IN_1_I,
    input wire logic PARALLEL_IN_2_I,
    input wire logic PARALLEL_IN_3_I,
    input wire logic [3:0] OVERCURRENT_I,
    input wire logic [3:0] OPEN_LOAD_I,
    input wire logic SUPPLY_FAULT_I,
    output logic DRIVER_0_O,
    output logic DRIVER_1_O,
    output logic DRIVER_2_O,
    output logic DRIVER_3_O,
    output logic SERIAL_OUT_O,
    output logic SERIAL_OUT_OE_O,
    output logic STATUS_O,
    output logic STATUS_OE_O
);

    // ---------------- Link domain, clocked by SCLK_I ----------------
    logic fresh_r;
    logic [3:0] cnt_r;
    logic [7:0] rx_r;
    logic [2:0] txi_r;
    logic so_r;
    logic [3:0] snap_r;
    // Response word and the index of the bit it presents next
    wire [7:0] resp = {4'h0, snap_r};
    wire [2:0] tx_sel = qld_pkg::TX_SEL_FIRST - txi_r;
    // Saturating count, so an overlong frame can never wrap back to eight
    wire [3:0] cnt_inc = (cnt_r == qld_pkg::CNT_MAX) ? cnt_r : cnt_r + 4'h1;

    // Marks the first rising edge of a frame; chip select high rearms it
    always_ff @(posedge SCLK_I or posedge CHIP_SELECT_N_I)
    begin
        if (CHIP_SELECT_N_I)
            fresh_r <= 1'b1;
        else
            fresh_r <= 1'b0;
    end

    // Shift in on rising edges only while selected; count saturates
    always_ff @(posedge SCLK_I)
    begin
        if (!CHIP_SELECT_N_I)
        begin
            rx_r <= {rx_r[6:0], SERIAL_IN_I};
            cnt_r <= fresh_r ? 4'h1 : cnt_inc;
        end
    end

    // Bit 7 is always zero, so the idle value doubles as the first bit
    always_ff @(negedge SCLK_I or posedge CHIP_SELECT_N_I)
    begin
        if (CHIP_SELECT_N_I)
        begin
            txi_r <= 3'h0;
            so_r <= 1'b0;
        end
        else
        begin
            txi_r <= txi_r + 3'h1;
            so_r <= resp[tx_sel];
        end
    end

    // Serial data straight from its falling-edge flop
    assign SERIAL_OUT_O = so_r;
    // Follows the pin itself so the line is released with no clock running
    assign SERIAL_OUT_OE_O = ~CHIP_SELECT_N_I;

    // ---------------- System domain, clocked by CLOCK_I ----------------
    logic [qld_pkg::PIN_W-1:0] pin_s1_r;
    logic [qld_pkg::PIN_W-1:0] pin_s2_r;
    logic cs_d_r;
    logic [3:0] cmd_r;
    logic latch_r;
    logic status_r;
    logic [3:0] drv_r;
    // Per-channel fault bits, each written by its own channel only
    wire [3:0] fault;

    wire [qld_pkg::PIN_W-1:0] pin_raw = {SUPPLY_FAULT_I, OPEN_LOAD_I, OVERCURRENT_I,
        PARALLEL_IN_3_I, PARALLEL_IN_2_I, PARALLEL_IN_1_I, PARALLEL_IN_0_I,
        CHIP_SELECT_N_I};

    // Two-flop synchronisers for every asynchronous input
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            pin_s1_r <= qld_pkg::PIN_RST;
            pin_s2_r <= qld_pkg::PIN_RST;
        end
        else
        begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Synchronised views of the pins; nothing reads the first stage
    wire cs_s = pin_s2_r[qld_pkg::PIN_CS];
    wire [3:0] par_s = pin_s2_r[qld_pkg::PIN_PAR +: 4];
    wire [3:0] oc_s = pin_s2_r[qld_pkg::PIN_OC +: 4];
    wire [3:0] ol_s = pin_s2_r[qld_pkg::PIN_OL +: 4];
    wire sup_s = pin_s2_r[qld_pkg::PIN_SUP];
    wire cs_rise = cs_s & ~cs_d_r;
    // The link is idle once chip select is seen high, so its words are stable
    wire accept = cs_rise & (cnt_r == qld_pkg::FRAME_CNT);

    // Command, supply latch and status; reset also serves as power-on reset
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            cs_d_r <= 1'b1;
            cmd_r <= qld_pkg::CMD_RST;
            latch_r <= 1'b0;
            status_r <= 1'b0;
        end
        else
        begin
            cs_d_r <= cs_s;
            if (accept)
                cmd_r <= rx_r[qld_pkg::CMD_LSB +: 4];
            if (sup_s)
                latch_r <= 1'b1;
            else if (accept)
                latch_r <= 1'b0;
            status_r <= |fault;
        end
    end

    // Snapshot follows faults while deselected and freezes at the fall;
    // the bits are first read at the fourth falling edge, well after the freeze
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
            snap_r <= 4'h0;
        else if (cs_s)
            snap_r <= fault;
    end

    // Open-drain status: data held low, the enable does the signalling
    assign STATUS_O = 1'b0;
    assign STATUS_OE_O = status_r;

    // Driver pins straight from their flops
    assign DRIVER_0_O = drv_r[0];
    assign DRIVER_1_O = drv_r[1];
    assign DRIVER_2_O = drv_r[2];
    assign DRIVER_3_O = drv_r[3];

    // Per-channel protection: overcurrent retry and open-load filter
    for (genvar g = 0; g < qld_pkg::CHANNELS; g++)
    begin : ch
        qld_pkg::oc_state_t st_r;
        qld_pkg::oc_state_t st_nxt;
        logic [qld_pkg::TMR_W-1:0] tmr_r;
        logic [qld_pkg::TMR_W-1:0] tmr_nxt;
        logic [qld_pkg::OL_W-1:0] olc_r;
        logic [qld_pkg::OL_W-1:0] olc_nxt;
        logic ocf_r;
        logic ocf_nxt;
        logic olf_r;
        logic olf_nxt;

        // A channel is wanted when either control source asks for it
        wire want = cmd_r[g] | par_s[g];
        wire drive = want & ~latch_r & ~sup_s & (st_r == qld_pkg::OC_RUN);
        // Terminal counts; each timer runs from zero to one less than its length
        wire sense_end = tmr_r == qld_pkg::TMR_W'(qld_pkg::OC_SENSE_CYC - 1);
        wire shut_end = tmr_r == qld_pkg::TMR_W'(SHUT_CYCLES - 1);
        wire ol_end = olc_r == qld_pkg::OL_W'(qld_pkg::OL_SENSE_CYC - 1);

        // Overcurrent: sense time on, then shutdown interval off, repeat
        // Retry duty follows from the sense time against the shutdown interval
        always_comb
        begin
            st_nxt = st_r;
            tmr_nxt = tmr_r;
            ocf_nxt = ocf_r;
            case (st_r)
                qld_pkg::OC_RUN:
                begin
                    if (drv_r[g] & oc_s[g])
                    begin
                        if (sense_end)
                        begin
                            st_nxt = qld_pkg::OC_SHUT;
                            tmr_nxt = '0;
                            ocf_nxt = 1'b1;
                        end
                        else
                            tmr_nxt = tmr_r + 1'b1;
                    end
                    else
                    begin
                        tmr_nxt = '0;
                        if (drv_r[g])
                            ocf_nxt = 1'b0;
                    end
                end
                qld_pkg::OC_SHUT:
                begin
                    if (shut_end)
                    begin
                        st_nxt = qld_pkg::OC_RUN;
                        tmr_nxt = '0;
                    end
                    else
                        tmr_nxt = tmr_r + 1'b1;
                end
                default:
                begin
                    st_nxt = qld_pkg::OC_RUN;
                    tmr_nxt = '0;
                end
            endcase
        end

        // Open load judged only while the channel is commanded off
        always_comb
        begin
            olc_nxt = '0;
            olf_nxt = olf_r;
            if (!ol_s[g])
                olf_nxt = 1'b0;
            else if (!want)
            begin
                if (ol_end)
                begin
                    olf_nxt = 1'b1;
                    olc_nxt = olc_r;
                end
                else
                    olc_nxt = olc_r + 1'b1;
            end
        end

        // Channel state; the driver flop sits here so each bit has one writer
        always_ff @(posedge CLOCK_I)
        begin
            if (RST_I)
            begin
                st_r <= qld_pkg::OC_RUN;
                tmr_r <= '0;
                olc_r <= '0;
                ocf_r <= 1'b0;
                olf_r <= 1'b0;
                drv_r[g] <= 1'b0;
            end
            else
            begin
                st_r <= st_nxt;
                tmr_r <= tmr_nxt;
                olc_r <= olc_nxt;
                ocf_r <= ocf_nxt;
                olf_r <= olf_nxt;
                drv_r[g] <= drive;
            end
        end

        // Either fault type raises the channel's bit
        assign fault[g] = ocf_r | olf_r;
    end

endmodule // quad_lowside_driver_serial_control

// ===== tb/qld_host_model.sv
// Host side of the serial link: frames, clock, select and data toward the block.
// Assumes the bench calls xfer by hierarchy, one frame at a time.
`timescale 1ns/1ps
module qld_host_model (
    output logic sclk_o,
    output logic chip_select_n_o,
    output logic serial_in_o,
    input wire logic serial_out_i,
    input wire logic serial_out_oe_i
);
    int half = 32;
    // Idle: clock parked low, select pulled up, data pulled down
    initial
    begin
        sclk_o = 1'b0;
        chip_select_n_o = 1'b1;
        serial_in_o = 1'b0;
    end
    // A short bit count gives a frame the block has to refuse
    task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] resp);
        resp = 8'h00;
        chip_select_n_o = 1'b0;
        #64;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            serial_in_o = cmd[i];
            #(half) sclk_o = 1'b1;
            resp[i] = serial_out_oe_i ? serial_out_i : 1'bx;
            #(half) sclk_o = 1'b0;
        end
        #80 chip_select_n_o = 1'b1;
        serial_in_o = 1'b0;
        #1000;
    endtask
endmodule // qld_host_model

// ===== tb/quad_lowside_driver_serial_control_monitor.sv
// Checker for the quad low-side driver control block; sees the top ports only.
// Assumes no frame lands inside a channel 0 retry window.
`timescale 1ns/1ps
module quad_lowside_driver_serial_control_monitor #(
    parameter int SHUT_CYCLES = 20
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CHIP_SELECT_N_I,
    input wire logic PARALLEL_IN_0_I,
    input wire logic [3:0] OVERCURRENT_I,
    input wire logic [3:0] OPEN_LOAD_I,
    input wire logic SUPPLY_FAULT_I,
    input wire logic DRIVER_0_O,
    input wire logic DRIVER_1_O,
    input wire logic DRIVER_2_O,
    input wire logic DRIVER_3_O,
    input wire logic SERIAL_OUT_O,
    input wire logic SERIAL_OUT_OE_O,
    input wire logic STATUS_O,
    input wire logic STATUS_OE_O
);
    logic [10:0] oc_run_r;
    logic [10:0] sense_run_r;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // Run lengths; the sensor count saturates so long faults cannot wrap it
    always_ff @(posedge CLOCK_I)
    begin
        oc_run_r <= (RST_I || !(OVERCURRENT_I[0] && DRIVER_0_O)) ? 11'h000 : oc_run_r + 11'h001;
        sense_run_r <= (RST_I || !(|{OVERCURRENT_I, OPEN_LOAD_I})) ? 11'h000
            : sense_run_r + {10'h000, ~&sense_run_r};
    end
    a_oe_tracks_cs: assert property (SERIAL_OUT_OE_O == !CHIP_SELECT_N_I)
        else $error("serial out enable wrong");
    a_status_data_low: assert property (STATUS_O == 1'b0) else $error("status data high");
    a_first_bit_zero: assert property ($fell(CHIP_SELECT_N_I) |-> !SERIAL_OUT_O)
        else $error("top response bit not zero");
    a_supply_forces_off: assert property (SUPPLY_FAULT_I [*5] |->
        !(DRIVER_0_O | DRIVER_1_O | DRIVER_2_O | DRIVER_3_O)) else $error("driver on in supply fault");
    a_rise_has_cause: assert property ($rose(DRIVER_0_O) |-> CHIP_SELECT_N_I
        || $past(PARALLEL_IN_0_I, 3) || $past(PARALLEL_IN_0_I, 4) || $past(PARALLEL_IN_0_I, 5))
        else $error("driver rose mid frame");
    a_fault_needs_time: assert property ($rose(STATUS_OE_O) |-> sense_run_r >= 11'h0FA)
        else $error("fault flagged too early");
    a_oc_cut_bound: assert property (oc_run_r < 11'h4EC) else $error("overcurrent not cut");
    a_shut_holds_off: assert property ($fell(DRIVER_0_O) && oc_run_r > 11'h4B0 |->
        !DRIVER_0_O [*8]) else $error("retry too soon");
    c_frame: cover property ($fell(CHIP_SELECT_N_I));
    c_fault: cover property ($rose(STATUS_OE_O));
    c_oc_cut: cover property ($fell(DRIVER_0_O) && OVERCURRENT_I[0]);
endmodule // quad_lowside_driver_serial_control_monitor

bind quad_lowside_driver_serial_control quad_lowside_driver_serial_control_monitor
    #(.SHUT_CYCLES(SHUT_CYCLES)) quad_lowside_driver_serial_control_monitor_i (.CLOCK_I, .RST_I,
    .CHIP_SELECT_N_I, .PARALLEL_IN_0_I, .OVERCURRENT_I, .OPEN_LOAD_I, .SUPPLY_FAULT_I,
    .DRIVER_0_O, .DRIVER_1_O, .DRIVER_2_O, .DRIVER_3_O, .SERIAL_OUT_O, .SERIAL_OUT_OE_O,
    .STATUS_O, .STATUS_OE_O);

// ===== tb/quad_lowside_driver_serial_control_bench.sv
// Self-checking bench: row table of command and parallel cases, then fault scenarios.
// Assumes the host model owns the link pins and the checker is bound in.
`timescale 1ns/1ps
module quad_lowside_driver_serial_control_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sup = 1'b0;
    logic [3:0] par = 4'h0;
    logic [3:0] oc = 4'h0;
    logic [3:0] ol = 4'h0;
    logic sclk, csn, si, so, so_oe, st, st_oe;
    wire [3:0] drv;
    logic [3:0] old;
    logic [7:0] resp;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    // Rows: parallel, command, expected drivers
    logic [11:0] rows [6] = '{12'h011, 12'h202, 12'h48C, 12'h0FF, 12'h5AF, 12'h000};
    always #25 clk = ~clk;
    quad_lowside_driver_serial_control #(.SHUT_CYCLES(20)) quad_lowside_driver_serial_control_i (
        .CLOCK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CHIP_SELECT_N_I(csn), .SERIAL_IN_I(si),
        .PARALLEL_IN_0_I(par[0]), .PARALLEL_IN_1_I(par[1]), .PARALLEL_IN_2_I(par[2]),
        .PARALLEL_IN_3_I(par[3]), .OVERCURRENT_I(oc), .OPEN_LOAD_I(ol), .SUPPLY_FAULT_I(sup),
        .DRIVER_0_O(drv[0]), .DRIVER_1_O(drv[1]), .DRIVER_2_O(drv[2]), .DRIVER_3_O(drv[3]),
        .SERIAL_OUT_O(so), .SERIAL_OUT_OE_O(so_oe), .STATUS_O(st), .STATUS_OE_O(st_oe));
    qld_host_model qld_host_model_i (.sclk_o(sclk), .chip_select_n_o(csn), .serial_in_o(si),
        .serial_out_i(so), .serial_out_oe_i(so_oe));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard well above the few thousand cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            errors++;
            end_of_test();
        end
    end
    initial
    begin
        step(6);
        rst <= 1'b0;
        step(4);
        chk({4'h0, drv}, 8'h00);
        chk({6'h00, st, so_oe}, 8'h00);
        old = 4'h0;
        foreach (rows[i])
        begin
            @(posedge clk);
            par <= rows[i][11:8];
            fork
                qld_host_model_i.xfer({4'hA, rows[i][7:4]}, 8, resp);
                begin
                    step(8);
                    chk({4'h0, drv}, {4'h0, old | rows[i][11:8]});
                end
            join
            step(6);
            chk({4'h0, drv}, {4'h0, rows[i][3:0]});
            chk(resp, 8'h00);
            old = rows[i][7:4];
        end
        qld_host_model_i.xfer(8'h0F, 7, resp);
        step(6);
        chk({4'h0, drv}, 8'h00);
        // Open load on an off channel: too short, then long enough, then gone
        ol <= 4'h4;
        step(200);
        chk({7'h00, st_oe}, 8'h00);
        step(100);
        chk({7'h00, st_oe}, 8'h01);
        qld_host_model_i.xfer(8'h00, 8, resp);
        chk(resp, 8'h04);
        @(posedge clk);
        ol <= 4'h0;
        step(6);
        chk({7'h00, st_oe}, 8'h00);
        qld_host_model_i.xfer(8'h04, 8, resp);
        @(posedge clk);
        ol <= 4'h4;
        step(300);
        chk({7'h00, st_oe}, 8'h00);
        ol <= 4'h0;
        qld_host_model_i.xfer(8'h00, 8, resp);
        @(posedge clk);
        // Overcurrent on channel 0: survives the sense time, cut, then retried
        par <= 4'h1;
        step(5);
        oc <= 4'h1;
        step(1200);
        chk({4'h0, drv}, 8'h01);
        step(60);
        chk({3'h0, st_oe, drv}, 8'h10);
        step(30);
        chk({4'h0, drv}, 8'h01);
        oc <= 4'h0;
        par <= 4'h0;
        step(8);
        chk({3'h0, st_oe, drv}, 8'h00);
        // Supply fault latches off until the next accepted frame
        qld_host_model_i.xfer(8'h0F, 8, resp);
        @(posedge clk);
        sup <= 1'b1;
        step(10);
        sup <= 1'b0;
        step(10);
        chk({4'h0, drv}, 8'h00);
        qld_host_model_i.xfer(8'h03, 8, resp);
        step(6);
        chk({4'h0, drv}, 8'h03);
        rst <= 1'b1;
        step(3);
        rst <= 1'b0;
        step(4);
        chk({4'h0, drv}, 8'h00);
        end_of_test();
    end
endmodule // quad_lowside_driver_serial_control_bench
